// *** common/hppsc_cfg.svh ***
`ifndef HPPSC_CFG_SVH
`define HPPSC_CFG_SVH
`define HPPSC_NUM_PORTS       4
`define HPPSC_ADDR_STATCMD    8'hF8
`define HPPSC_STATCMD_RESET   8'h00
`define HPPSC_STATCMD_WMASK   8'h03
`define HPPSC_BIT_CFG_LOCK    0
`define HPPSC_BIT_SW_RESET    1
`define HPPSC_XLAT_BUFS       4
`define HPPSC_CLK_HZ          24000000
`endif

// *** common/hppsc_pkg.sv ***
`default_nettype none
package hppsc_pkg;
    typedef enum logic [2:0] {
        HPPSC_SPD_SS = 3'h1,
        HPPSC_SPD_HS = 3'h2,
        HPPSC_SPD_FS = 3'h4
    } hppsc_speed_t;
    typedef enum logic [2:0] {
        HPPSC_PWR_OFF  = 3'h1,
        HPPSC_PWR_ON   = 3'h2,
        HPPSC_PWR_TRIP = 3'h4
    } hppsc_gang_t;
endpackage
`default_nettype wire

// *** logic/hppsc_cfg_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "hppsc_cfg.svh"
// Small configuration store; read data registered
module hppsc_cfg_mem (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem_reg [0:3];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 4; i++) begin
                mem_reg[i] <= 8'h00;
            end
            rdata_o <= 8'h00;
        end else begin
            if (we_i && addr_i[7:2] == 6'h00) begin
                mem_reg[addr_i[1:0]] <= wdata_i;
            end
            rdata_o <= (addr_i[7:2] == 6'h00) ? mem_reg[addr_i[1:0]] : 8'h00;
        end
    end
endmodule // hppsc_cfg_mem
`default_nettype wire

// *** logic/hppsc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "hppsc_cfg.svh"
module hppsc_top (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       up_ss_conn_i,
    input  wire logic       up_hs_conn_i,
    input  wire logic       up_fs_only_i,
    input  wire logic       up_ss_susp_i,
    input  wire logic       up_hs_susp_i,
    input  wire logic       ganged_mode_i,
    input  wire logic [2:0] port_count_i,
    input  wire logic [3:0] port_disable_i,
    input  wire logic [3:0] port_removable_i,
    input  wire logic [3:0] port_charge_en_i,
    input  wire logic [3:0] host_pwr_req_i,
    input  wire logic [3:0] pwr_off_ok_i,
    input  wire logic [3:0] ovc_n_i,
    input  wire logic       reg_we_i,
    input  wire logic       reg_eeprom_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic [3:0]      port_pwr_en_o,
    output logic [3:0]      port_ss_en_o,
    output logic [3:0]      port_hs_en_o,
    output logic [3:0]      port_ovc_o,
    output logic [3:0]      port_removable_o,
    output logic [3:0]      charging_downstream_mode_o,
    output logic [3:0]      dedicated_charger_mode_o,
    output logic [2:0]      port_count_o,
    output logic [3:0]      xlat_buf_count_o,
    output logic            hs_up_conn_o,
    output logic            hs_up_susp_o,
    output logic            ss_up_conn_o,
    output logic            ss_up_susp_o
);
    // Clamp count into 1..4
    function automatic logic [2:0] clamp_count(input logic [2:0] c);
        if (c == 3'h0) begin
            clamp_count = 3'h1;
        end else if (c > 3'h4) begin
            clamp_count = 3'h4;
        end else begin
            clamp_count = c;
        end
    endfunction

    logic [3:0] ovc_meta_reg;
    logic [3:0] ovc_sync_reg;
    logic [3:0] port_en;
    logic [7:0] statcmd_reg;
    logic [7:0] mem_rdata;
    logic       mem_we;
    logic       rd_statcmd_reg;
    logic       sw_reset;
    logic       up_conn;
    logic [3:0] gang_need;
    hppsc_pkg::hppsc_speed_t speed_reg;
    hppsc_pkg::hppsc_gang_t  gang_reg;
    logic [3:0] ind_pwr_reg;

    // First stage read only by the second
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovc_meta_reg <= 4'hF;
            ovc_sync_reg <= 4'hF;
        end else begin
            ovc_meta_reg <= ovc_n_i;
            ovc_sync_reg <= ovc_meta_reg;
        end
    end

    assign sw_reset = statcmd_reg[`HPPSC_BIT_SW_RESET];
    assign up_conn  = up_ss_conn_i | up_hs_conn_i;

    genvar g;
    generate
        for (g = 0; g < `HPPSC_NUM_PORTS; g++) begin : g_port
            // Ports beyond the reported count are treated as disabled
            assign port_en[g] = ~port_disable_i[g] &
                                (3'(g) < clamp_count(port_count_i));
            assign gang_need[g] = port_en[g] & host_pwr_req_i[g] & ~pwr_off_ok_i[g];
        end
    endgenerate

    // Register file access; EEPROM loads never reach the status register
    assign mem_we = reg_we_i & (reg_addr_i != `HPPSC_ADDR_STATCMD);

    hppsc_cfg_mem u_mem (
        .clk_i   (ref_clk_i),
        .rst_n_i (rst_n_i),
        .we_i    (mem_we),
        .addr_i  (reg_addr_i),
        .wdata_i (reg_wdata_i),
        .rdata_o (mem_rdata)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            statcmd_reg <= `HPPSC_STATCMD_RESET;
        end else if (sw_reset) begin
            // Self-clearing soft reset bit
            statcmd_reg <= statcmd_reg & ~(8'h01 << `HPPSC_BIT_SW_RESET);
        end else if (reg_we_i && !reg_eeprom_i && reg_addr_i == `HPPSC_ADDR_STATCMD) begin
            statcmd_reg <= reg_wdata_i & `HPPSC_STATCMD_WMASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_statcmd_reg <= 1'b0;
        end else begin
            rd_statcmd_reg <= (reg_addr_i == `HPPSC_ADDR_STATCMD);
        end
    end

    // Output register adds one cycle after the memory stage
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rd_statcmd_reg ? statcmd_reg : mem_rdata;
        end
    end

    // Upstream speed class decides downstream speed enables
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            speed_reg <= hppsc_pkg::HPPSC_SPD_FS;
        end else if (up_ss_conn_i) begin
            speed_reg <= hppsc_pkg::HPPSC_SPD_SS;
        end else if (up_hs_conn_i && !up_fs_only_i) begin
            speed_reg <= hppsc_pkg::HPPSC_SPD_HS;
        end else begin
            speed_reg <= hppsc_pkg::HPPSC_SPD_FS;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_ss_en_o <= 4'h0;
            port_hs_en_o <= 4'h0;
        end else begin
            case (speed_reg)
                hppsc_pkg::HPPSC_SPD_SS: begin
                    port_ss_en_o <= port_en;
                    port_hs_en_o <= port_en;
                end
                hppsc_pkg::HPPSC_SPD_HS: begin
                    port_ss_en_o <= 4'h0;
                    port_hs_en_o <= port_en;
                end
                hppsc_pkg::HPPSC_SPD_FS: begin
                    port_ss_en_o <= 4'h0;
                    port_hs_en_o <= 4'h0;
                end
                default: begin
                    port_ss_en_o <= 4'h0;
                    port_hs_en_o <= 4'h0;
                end
            endcase
        end
    end

    // Per-port power: a tripped port stays off until host drops its request
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ind_pwr_reg <= 4'h0;
        end else if (sw_reset) begin
            ind_pwr_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (!ovc_sync_reg[i]) begin
                    ind_pwr_reg[i] <= 1'b0;
                end else if (!host_pwr_req_i[i]) begin
                    ind_pwr_reg[i] <= 1'b0;
                end else if (!port_ovc_o[i]) begin
                    ind_pwr_reg[i] <= 1'b1;
                end
            end
        end
    end

    // Ganged power state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gang_reg <= hppsc_pkg::HPPSC_PWR_OFF;
        end else if (sw_reset) begin
            gang_reg <= hppsc_pkg::HPPSC_PWR_OFF;
        end else begin
            case (gang_reg)
                hppsc_pkg::HPPSC_PWR_OFF: begin
                    if (ovc_sync_reg != 4'hF) begin
                        gang_reg <= hppsc_pkg::HPPSC_PWR_TRIP;
                    end else if (gang_need != 4'h0) begin
                        gang_reg <= hppsc_pkg::HPPSC_PWR_ON;
                    end
                end
                hppsc_pkg::HPPSC_PWR_ON: begin
                    if (ovc_sync_reg != 4'hF) begin
                        gang_reg <= hppsc_pkg::HPPSC_PWR_TRIP;
                    end else if (gang_need == 4'h0) begin
                        gang_reg <= hppsc_pkg::HPPSC_PWR_OFF;
                    end
                end
                hppsc_pkg::HPPSC_PWR_TRIP: begin
                    // Re-arm only once gang_need drops to zero and the fault clears
                    if (ovc_sync_reg == 4'hF && gang_need == 4'h0) begin
                        gang_reg <= hppsc_pkg::HPPSC_PWR_OFF;
                    end
                end
                default: gang_reg <= hppsc_pkg::HPPSC_PWR_OFF;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_pwr_en_o <= 4'h0;
            port_ovc_o    <= 4'h0;
        end else begin
            if (ganged_mode_i) begin
                port_pwr_en_o <= (gang_reg == hppsc_pkg::HPPSC_PWR_ON) ? port_en : 4'h0;
            end else begin
                port_pwr_en_o <= ind_pwr_reg & port_en & ovc_sync_reg;
            end
            // Sticky per-port fault, set wins over host clear
            for (int i = 0; i < 4; i++) begin
                if (!ovc_sync_reg[i]) begin
                    port_ovc_o[i] <= 1'b1;
                end else if (!host_pwr_req_i[i]) begin
                    port_ovc_o[i] <= 1'b0;
                end
            end
        end
    end

    // Config, charging mode and upstream status outputs
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            port_removable_o           <= 4'h0;
            charging_downstream_mode_o <= 4'h0;
            dedicated_charger_mode_o   <= 4'h0;
            port_count_o               <= 3'h1;
            xlat_buf_count_o           <= 4'h0;
            hs_up_conn_o               <= 1'b0;
            hs_up_susp_o               <= 1'b0;
            ss_up_conn_o               <= 1'b0;
            ss_up_susp_o               <= 1'b0;
        end else begin
            port_removable_o           <= port_removable_i & port_en;
            charging_downstream_mode_o <= up_conn ? (port_charge_en_i & port_en) : 4'h0;
            dedicated_charger_mode_o   <= up_conn ? 4'h0 : (port_charge_en_i & port_en);
            port_count_o               <= clamp_count(port_count_i);
            xlat_buf_count_o           <= 4'(`HPPSC_XLAT_BUFS);
            hs_up_conn_o               <= up_hs_conn_i;
            hs_up_susp_o               <= up_hs_conn_i & up_hs_susp_i;
            ss_up_conn_o               <= up_ss_conn_i;
            ss_up_susp_o               <= up_ss_conn_i & up_ss_susp_i;
        end
    end

    property p_ss_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !up_ss_conn_i |=> ##1 (port_ss_en_o == 4'h0);
    endproperty
    a_ss_off: assert property (p_ss_off) else $error("SS enabled without SS upstream");

    property p_hs_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!up_ss_conn_i && (!up_hs_conn_i || up_fs_only_i)) |=> ##1 (port_hs_en_o == 4'h0);
    endproperty
    a_hs_off: assert property (p_hs_off) else $error("HS enabled on FS upstream");

    property p_count;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 (port_count_o >= 3'h1 && port_count_o <= 3'h4);
    endproperty
    a_count: assert property (p_count) else $error("Port count out of range");

    property p_ind_ovc;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !ganged_mode_i |=> ((port_pwr_en_o & ~$past(ovc_sync_reg)) == 4'h0);
    endproperty
    a_ind_ovc: assert property (p_ind_ovc) else $error("Port powered in fault");

    property p_gang_ovc;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ganged_mode_i && $stable(ganged_mode_i) && ovc_sync_reg != 4'hF) |=> ##1 (port_pwr_en_o == 4'h0);
    endproperty
    a_gang_ovc: assert property (p_gang_ovc) else $error("Ganged power on during fault");

    property p_gang_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (gang_reg == hppsc_pkg::HPPSC_PWR_ON && gang_need != 4'h0 && ovc_sync_reg == 4'hF)
            |=> gang_reg == hppsc_pkg::HPPSC_PWR_ON;
    endproperty
    a_gang_hold: assert property (p_gang_hold) else $error("Ganged power dropped early");

    property p_disabled;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        1'b1 |=> ((port_pwr_en_o & ~$past(port_en)) == 4'h0);
    endproperty
    a_disabled: assert property (p_disabled) else $error("Disabled port powered");

    property p_statcmd;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (reg_we_i && reg_eeprom_i && reg_addr_i == `HPPSC_ADDR_STATCMD && !sw_reset)
            |=> $stable(statcmd_reg);
    endproperty
    a_statcmd: assert property (p_statcmd) else $error("EEPROM wrote status register");

    property p_chg_mode;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        up_conn |=> (dedicated_charger_mode_o == 4'h0);
    endproperty
    a_chg_mode: assert property (p_chg_mode) else $error("Dedicated charger while connected");

    c_gang_on: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        gang_reg == hppsc_pkg::HPPSC_PWR_ON);
    c_gang_trip: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        gang_reg == hppsc_pkg::HPPSC_PWR_TRIP);
    c_hs_only: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        speed_reg == hppsc_pkg::HPPSC_SPD_HS);
endmodule // hppsc_top
`default_nettype wire

// *** test/hppsc_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Upstream host: link state and port power requests, updated on the edge
module hppsc_host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [4:0] link_i,
    input  wire logic [3:0] req_i,
    output logic            up_ss_conn_o,
    output logic            up_hs_conn_o,
    output logic            up_fs_only_o,
    output logic            up_ss_susp_o,
    output logic            up_hs_susp_o,
    output logic [3:0]      host_pwr_req_o
);
    initial begin
        {up_hs_susp_o, up_ss_susp_o, up_fs_only_o, up_hs_conn_o, up_ss_conn_o} = 5'h00;
        host_pwr_req_o = 4'h0;
    end
    // Inputs taken at the edge, so the bench's post-edge drive never races us
    always @(posedge ref_clk_i) begin
        // A full-speed-only link cannot also carry SuperSpeed
        up_ss_conn_o <= link_i[0] & ~link_i[2];
        {up_hs_susp_o, up_ss_susp_o, up_fs_only_o, up_hs_conn_o} <= link_i[4:1];
        host_pwr_req_o <= req_i;
    end
endmodule // hppsc_host_model
`default_nettype wire

// *** test/hppsc_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module hppsc_top_tb;
    typedef struct packed {
        logic [4:0] link;
        logic [2:0] cnt;
        logic [3:0] chg;
        logic [3:0] rem;
        logic       spd;
        logic [3:0] ss;
        logic [3:0] hs;
        logic [3:0] chg_dn;
        logic [3:0] chg_dd;
        logic [2:0] cnt_o;
        logic [3:0] rem_o;
        logic [3:0] st;
    } hppsc_row_t;
    // Link bits: hs_susp, ss_susp, fs_only, hs_conn, ss_conn
    // Ports beyond the count read as disabled; st is hs_conn, hs_susp, ss_conn, ss_susp
    localparam hppsc_row_t ROWS [0:4] = '{
        '{5'h03, 3'h0, 4'hF, 4'hA, 1'b1, 4'h1, 4'h1, 4'h1, 4'h0, 3'h1, 4'h0, 4'hA},
        '{5'h02, 3'h2, 4'h5, 4'h5, 1'b1, 4'h0, 4'h3, 4'h1, 4'h0, 3'h2, 4'h1, 4'h8},
        '{5'h16, 3'h4, 4'h3, 4'h0, 1'b1, 4'h0, 4'h0, 4'h3, 4'h0, 3'h4, 4'h0, 4'hC},
        '{5'h00, 3'h7, 4'hC, 4'hF, 1'b1, 4'h0, 4'h0, 4'h0, 4'hC, 3'h4, 4'hF, 4'h0},
        '{5'h0B, 3'h3, 4'hF, 4'h3, 1'b1, 4'h7, 4'h7, 4'h7, 4'h0, 3'h3, 4'h3, 4'hB}};
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [4:0] link = 5'h00;
    logic [3:0] req = 4'h0;
    logic       gang = 1'b0;
    logic [2:0] cnt = 3'h0;
    logic [3:0] dis = 4'h0;
    logic [3:0] rem = 4'h0;
    logic [3:0] chg = 4'h0;
    logic [3:0] ok = 4'h0;
    logic [3:0] ovc_n = 4'hF;
    logic       we = 1'b0;
    logic       ee = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic       ss_c, hs_c, fs_o, ss_s, hs_s, hs_uc, hs_us, ss_uc, ss_us;
    logic [3:0] hreq, pwr, ss_en, hs_en, povc, prem, chg_dn, chg_dd, ttb;
    logic [7:0] rdata, v;
    logic [2:0] cnt_o;
    int         failures = 0;
    int         checked = 0;

    hppsc_host_model i_host (.ref_clk_i(clk), .link_i(link), .req_i(req),
        .up_ss_conn_o(ss_c), .up_hs_conn_o(hs_c), .up_fs_only_o(fs_o),
        .up_ss_susp_o(ss_s), .up_hs_susp_o(hs_s), .host_pwr_req_o(hreq));
    hppsc_top i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .up_ss_conn_i(ss_c),
        .up_hs_conn_i(hs_c), .up_fs_only_i(fs_o), .up_ss_susp_i(ss_s), .up_hs_susp_i(hs_s),
        .ganged_mode_i(gang), .port_count_i(cnt), .port_disable_i(dis),
        .port_removable_i(rem), .port_charge_en_i(chg), .host_pwr_req_i(hreq),
        .pwr_off_ok_i(ok), .ovc_n_i(ovc_n), .reg_we_i(we), .reg_eeprom_i(ee),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .port_pwr_en_o(pwr),
        .port_ss_en_o(ss_en), .port_hs_en_o(hs_en), .port_ovc_o(povc),
        .port_removable_o(prem), .charging_downstream_mode_o(chg_dn),
        .dedicated_charger_mode_o(chg_dd), .port_count_o(cnt_o), .xlat_buf_count_o(ttb),
        .hs_up_conn_o(hs_uc), .hs_up_susp_o(hs_us), .ss_up_conn_o(ss_uc),
        .ss_up_susp_o(ss_us));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic e);
        addr = a;
        wd = d;
        ee = e;
        we = 1'b1;
        step(1);
        we = 1'b0;
        ee = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        step(2);
        d = rdata;
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Power checks wait out request pipe, sync stages and output flop
    task automatic pwr_is(input logic [3:0] exp);
        step(8);
        chk("port_pwr_en", 8'(exp), 8'(pwr));
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        summarize();
    end

    initial begin
        step(20);
        chk("count_in_reset", 8'h01, 8'(cnt_o));
        chk("pwr_in_reset", 8'h00, 8'(pwr));
        rst_n = 1'b1;
        step(2);
        for (int i = 0; i < 5; i++) begin
            link = ROWS[i].link;
            cnt = ROWS[i].cnt;
            chg = ROWS[i].chg;
            rem = ROWS[i].rem;
            step(6);
            chk("charge_downstream", 8'(ROWS[i].chg_dn), 8'(chg_dn));
            chk("charge_dedicated", 8'(ROWS[i].chg_dd), 8'(chg_dd));
            chk("removable", 8'(ROWS[i].rem_o), 8'(prem));
            chk("count", 8'(ROWS[i].cnt_o), 8'(cnt_o));
            chk("status", 8'(ROWS[i].st), 8'({hs_uc, hs_us, ss_uc, ss_us}));
            if (ROWS[i].spd) begin
                chk("ss_en", 8'(ROWS[i].ss), 8'(ss_en));
                chk("hs_en", 8'(ROWS[i].hs), 8'(hs_en));
            end
        end
        chk("translator_bufs", 8'h04, 8'(ttb));
        $display("test table done");
        wr(8'hF8, 8'hFF, 1'b0);
        rd(8'hF8, v);
        chk("statcmd", 8'h01, v);
        wr(8'hF8, 8'h00, 1'b1);
        rd(8'hF8, v);
        chk("statcmd_eeprom", 8'h01, v);
        rd(8'h55, v);
        chk("unmapped", 8'h00, v);
        wr(8'h02, 8'h5A, 1'b0);
        rd(8'h02, v);
        chk("config_mem", 8'h5A, v);
        $display("test registers done");
        // All four ports counted for the power tests
        cnt = 3'h4;
        req = 4'hF;
        pwr_is(4'hF);
        req = 4'h5;
        pwr_is(4'h5);
        req = 4'hF;
        ovc_n = 4'hD;
        pwr_is(4'hD);
        chk("port_ovc", 8'h02, 8'(povc));
        ovc_n = 4'hF;
        req = 4'hD;
        step(4);
        req = 4'hF;
        pwr_is(4'hF);
        dis = 4'h4;
        pwr_is(4'hB);
        $display("test per-port power done");
        dis = 4'h0;
        // Earlier fault left the ganged state tripped; drop needs to re-arm it
        req = 4'h0;
        step(4);
        gang = 1'b1;
        req = 4'h1;
        pwr_is(4'hF);
        req = 4'h3;
        ok = 4'h1;
        pwr_is(4'hF);
        ok = 4'hF;
        pwr_is(4'h0);
        ok = 4'h0;
        dis = 4'h8;
        pwr_is(4'h7);
        dis = 4'h0;
        pwr_is(4'hF);
        ovc_n = 4'hB;
        pwr_is(4'h0);
        $display("test ganged power done");
        ovc_n = 4'hF;
        req = 4'h0;
        step(6);
        req = 4'h1;
        pwr_is(4'hF);
        rst_n = 1'b0;
        #5;
        chk("pwr_reset", 8'h00, 8'(pwr));
        chk("count_reset", 8'h01, 8'(cnt_o));
        step(3);
        rst_n = 1'b1;
        step(1);
        rd(8'hF8, v);
        chk("statcmd_reset", 8'h00, v);
        $display("test reset done");
        summarize();
    end
endmodule // hppsc_top_tb
`default_nettype wire
